// >>> rtl/isih_defines.vh
`ifndef ISIH_DEFINES_VH
`define ISIH_DEFINES_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ISIH_OFS_MODE 32'hFFF84000
`define ISIH_OFS_OWN_ADDR 32'hFFF84008
`define ISIH_OFS_STATUS 32'hFFF84020
`define ISIH_OFS_IRQ_SET 32'hFFF84024
`define ISIH_OFS_IRQ_CLR 32'hFFF84028
`define ISIH_OFS_IRQ_MASK 32'hFFF8402C
`define ISIH_OFS_RX_HOLD 32'hFFF84030
`define ISIH_OFS_TX_HOLD 32'hFFF84034

// ----------------------------------------
// status and mask bit positions
// ----------------------------------------
`define ISIH_BIT_TRANSFER_COMPLETE 0
`define ISIH_BIT_RX_READY 1
`define ISIH_BIT_TX_READY 2
`define ISIH_BIT_SLAVE_READ_DIR 3
`define ISIH_BIT_SLAVE_ACCESS 4
`define ISIH_BIT_GENERAL_CALL_SEEN 5
`define ISIH_BIT_OVERRUN_ERROR 6
`define ISIH_BIT_NACK 8
`define ISIH_BIT_ARBLOST 9
`define ISIH_BIT_CLKWAIT 10
`define ISIH_BIT_END_OF_SLAVE_ACCESS 11

// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define ISIH_MODE_MASTER_BIT 0
`define ISIH_MODE_SLAVE_BIT 1
`define ISIH_OWN_ADDR_LSB 16
`define ISIH_OWN_ADDR_MSB 22
`define ISIH_FLAG_W 12

// ----------------------------------------
// reset and constant values
// ----------------------------------------
`define ISIH_IRQ_VALID 12'hF77
`define ISIH_MASK_RESET 12'h000
`define ISIH_STATUS_HIGH_ONES 4'hF
`define ISIH_BYTE_RESET 8'h00
`define ISIH_OWN_ADDR_RESET 7'h00
`define ISIH_GEN_CALL_ADDR 7'h00
`define ISIH_BITS_PER_BYTE 4'h8
`define ISIH_LAST_TX_BIT 4'h7

`endif

// >>> rtl/isih_sync2.v
`timescale 1ns/1ps

// ----------------------------------------
// two-stage synchroniser for one pin
// ----------------------------------------
module isih_sync2 (
  input wire core_clk, // block clock
  input wire rst_n, // synchronous reset, active low
  input wire pinIn, // asynchronous pin level
  input wire resetVal, // constant idle level of the pin
  output reg syncOut // level in the core_clk domain
);

  reg stage1_q;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      stage1_q <= resetVal;
      syncOut <= resetVal;
    end else begin
      stage1_q <= pinIn;
      syncOut <= stage1_q;
    end
  end

endmodule // isih_sync2

// >>> rtl/isih_status_irq.v
// Contract
// - master data nack sets flag and completion
// - slave read: master nack sets flag
// - slave write: acknowledge every received byte
// - master arbitration loss sets flag, completion
// - slave stretches clock, wait flag while stalled
// - end-of-access flag when slave access falls
// - enable register ones set mask bits
// - disable register ones clear mask bits
// - mask view readable, zero after reset
// - fixed bit positions, bit seven unused
// - receive holding byte in low bits
// - transmit holding takes next byte
// - slave access on match until nack/stop
// - slave stops sending after nack
// - master completion after stop sent, data nack or arbitration loss
`timescale 1ns/1ps
`include "isih_defines.vh"

module isih_status_irq (
  input wire core_clk, // block clock, 200 MHz
  input wire rst_n, // synchronous reset, active low
  input wire [31:0] regAddr, // register byte address
  input wire [31:0] regWdata, // register write data
  input wire regWr, // write strobe
  input wire regRd, // read strobe
  output reg [31:0] regRdata, // read data, cycle after strobe
  input wire sclIn, // serial clock pin level
  output wire sclOut, // serial clock drive level
  output wire sclOe, // serial clock drive enable
  input wire sdaIn, // serial data pin level
  output wire sdaOut, // serial data drive level
  output wire sdaOe, // serial data drive enable
  input wire mstStart, // master engine starts a frame
  input wire mstTxTake, // master engine took the transmit byte
  input wire mstRxValid, // master engine received a byte
  input wire [7:0] mstRxByte, // byte from master engine
  input wire mstByteNack, // slave did not ack a data byte
  input wire mstArbLost, // another master won arbitration
  input wire mstDone, // shifters empty and stop sent
  output wire [7:0] txByte, // byte for the master engine
  output wire txPending, // transmit holding register full
  output wire masterEn, // master mode enabled
  output wire slaveEn, // slave mode enabled
  output wire irq // interrupt request, active high
);

  // ----------------------------------------
  // slave states
  // ----------------------------------------
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_ACKA = 7'h04;
  localparam [6:0] ST_WDATA = 7'h08;
  localparam [6:0] ST_WACK = 7'h10;
  localparam [6:0] ST_RDATA = 7'h20;
  localparam [6:0] ST_RACK = 7'h40;

  reg modeMaster_q;
  reg modeSlave_q;
  reg [6:0] ownAddr_q;
  reg [11:0] mask_q;
  reg [7:0] txHold_q;
  reg [7:0] rxHold_q;
  reg transfer_complete_q;
  reg rx_ready_q;
  reg tx_ready_q;
  reg slave_read_dir_q;
  reg slave_access_q;
  reg general_call_seen_q;
  reg overrun_error_q;
  reg nack_q;
  reg arbLost_q;
  reg end_of_slave_access_q;
  reg stretch_q;
  reg sdaDrv_q;
  reg [6:0] state_q;
  reg [3:0] bitCnt_q;
  reg [7:0] shift_q;
  reg sclPrev_q;
  reg sdaPrev_q;
  wire sclS;
  wire sdaS;

  // ----------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------
  isih_sync2 u_scl_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(sclIn),
    .resetVal(1'b1),
    .syncOut(sclS)
  );

  isih_sync2 u_sda_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(sdaIn),
    .resetVal(1'b1),
    .syncOut(sdaS)
  );

  always @(posedge core_clk) begin
    if (!rst_n) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  wire sclRise = sclS & ~sclPrev_q;
  wire sclFall = ~sclS & sclPrev_q;
  wire startDet = slaveEn & sclS & sclPrev_q & ~sdaS & sdaPrev_q;
  wire stopDet = slaveEn & sclS & sclPrev_q & sdaS & ~sdaPrev_q;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  wire wrMode = regWr & (regAddr == `ISIH_OFS_MODE);
  wire wrOwn = regWr & (regAddr == `ISIH_OFS_OWN_ADDR);
  wire wrIrqSet = regWr & (regAddr == `ISIH_OFS_IRQ_SET);
  wire wrIrqClr = regWr & (regAddr == `ISIH_OFS_IRQ_CLR);
  wire wrTx = regWr & (regAddr == `ISIH_OFS_TX_HOLD);
  wire rdStatus = regRd & (regAddr == `ISIH_OFS_STATUS);
  wire rdRx = regRd & (regAddr == `ISIH_OFS_RX_HOLD);

  assign masterEn = modeMaster_q;
  assign slaveEn = modeSlave_q & ~modeMaster_q;

  wire newMaster = regWdata[`ISIH_MODE_MASTER_BIT];
  wire newSlave = regWdata[`ISIH_MODE_SLAVE_BIT];
  wire masterEnRise = wrMode & newMaster & ~modeMaster_q;
  wire slaveEnRise = wrMode & newSlave & ~newMaster & ~slaveEn;

  // ----------------------------------------
  // slave engine events
  // ----------------------------------------
  wire stIdle = (state_q == ST_IDLE);
  wire stAddr = (state_q == ST_ADDR);
  wire stAcka = (state_q == ST_ACKA);
  wire stWdata = (state_q == ST_WDATA);
  wire stWack = (state_q == ST_WACK);
  wire stRdata = (state_q == ST_RDATA);
  wire stRack = (state_q == ST_RACK);

  wire adrHit = (shift_q[7:1] == ownAddr_q);
  wire gcHit = (shift_q[7:1] == `ISIH_GEN_CALL_ADDR) & ~shift_q[0];
  wire addrEnd = stAddr & sclFall & (bitCnt_q == `ISIH_BITS_PER_BYTE);
  wire ackAddr = addrEnd & (adrHit | gcHit);
  wire rxLoad = stWdata & ~stretch_q & sclFall & (bitCnt_q == `ISIH_BITS_PER_BYTE);
  wire ackSample = stRack & sclRise;
  wire slvNack = ackSample & sdaS;
  // byte goes out only with holding register full and no nack pending
  wire thrLoad = stRdata & stretch_q & ~tx_ready_q & ~nack_q;
  wire svAccEnd = slave_access_q & (stopDet | slvNack);

  // ----------------------------------------
  // slave byte state machine
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= `ISIH_BYTE_RESET;
      sdaDrv_q <= 1'b0;
      stretch_q <= 1'b0;
    end else if (!slaveEn || stopDet) begin
      state_q <= ST_IDLE;
      sdaDrv_q <= 1'b0;
      stretch_q <= 1'b0;
    end else if (startDet) begin
      state_q <= ST_ADDR;
      bitCnt_q <= 4'h0;
      sdaDrv_q <= 1'b0;
      stretch_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sdaDrv_q <= 1'b0;
        end
        ST_ADDR: begin
          if (sclRise) begin
            shift_q <= {shift_q[6:0], sdaS};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (addrEnd) begin
            if (adrHit | gcHit) begin
              state_q <= ST_ACKA;
              sdaDrv_q <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ACKA: begin
          if (sclFall) begin
            sdaDrv_q <= 1'b0;
            bitCnt_q <= 4'h0;
            stretch_q <= 1'b1;
            if (slave_read_dir_q) begin
              state_q <= ST_RDATA;
            end else begin
              state_q <= ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (stretch_q) begin
            if (!rx_ready_q) begin
              stretch_q <= 1'b0;
            end
          end else if (sclRise) begin
            shift_q <= {shift_q[6:0], sdaS};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (rxLoad) begin
            state_q <= ST_WACK;
            sdaDrv_q <= 1'b1;
          end
        end
        ST_WACK: begin
          if (sclFall) begin
            state_q <= ST_WDATA;
            sdaDrv_q <= 1'b0;
            bitCnt_q <= 4'h0;
            stretch_q <= 1'b1;
          end
        end
        ST_RDATA: begin
          if (stretch_q) begin
            if (nack_q) begin
              state_q <= ST_IDLE;
              stretch_q <= 1'b0;
            end else if (thrLoad) begin
              shift_q <= txHold_q;
              sdaDrv_q <= ~txHold_q[7];
              bitCnt_q <= 4'h0;
              stretch_q <= 1'b0;
            end
          end else if (sclFall) begin
            if (bitCnt_q == `ISIH_LAST_TX_BIT) begin
              state_q <= ST_RACK;
              sdaDrv_q <= 1'b0;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              sdaDrv_q <= ~shift_q[6];
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (slvNack) begin
            state_q <= ST_IDLE;
          end else if (sclFall) begin
            state_q <= ST_RDATA;
            stretch_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          sdaDrv_q <= 1'b0;
          stretch_q <= 1'b0;
        end
      endcase
    end
  end

  // open-drain: only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe = sdaDrv_q;
  assign sclOut = 1'b0;
  assign sclOe = stretch_q;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      modeMaster_q <= 1'b0;
      modeSlave_q <= 1'b0;
      ownAddr_q <= `ISIH_OWN_ADDR_RESET;
      mask_q <= `ISIH_MASK_RESET;
      txHold_q <= `ISIH_BYTE_RESET;
    end else begin
      if (wrMode) begin
        modeMaster_q <= newMaster;
        modeSlave_q <= newSlave;
      end
      // own address only changes while slave mode is off
      if (wrOwn && !slaveEn) begin
        ownAddr_q <= regWdata[`ISIH_OWN_ADDR_MSB:`ISIH_OWN_ADDR_LSB];
      end
      if (wrIrqSet) begin
        mask_q <= mask_q | (regWdata[11:0] & `ISIH_IRQ_VALID);
      end else if (wrIrqClr) begin
        mask_q <= mask_q & ~(regWdata[11:0] & `ISIH_IRQ_VALID);
      end
      if (wrTx) begin
        txHold_q <= regWdata[7:0];
      end
    end
  end

  assign txByte = txHold_q;
  assign txPending = ~tx_ready_q;

  // ----------------------------------------
  // status flags, set wins over clear
  // ----------------------------------------
  wire mNack = masterEn & mstByteNack;
  wire mArb = masterEn & mstArbLost;
  wire mRx = masterEn & mstRxValid;
  wire rxSet = mRx | rxLoad;
  wire compSet = (masterEn & mstDone) | mNack | mArb | stopDet;
  wire compClr = (masterEn & mstStart) | startDet;
  wire txRdySet = (masterEn & mstTxTake) | mNack | masterEnRise | slaveEnRise | ackSample;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      transfer_complete_q <= 1'b1;
      rx_ready_q <= 1'b0;
      tx_ready_q <= 1'b0;
      slave_read_dir_q <= 1'b1;
      slave_access_q <= 1'b0;
      general_call_seen_q <= 1'b0;
      overrun_error_q <= 1'b0;
      nack_q <= 1'b0;
      arbLost_q <= 1'b0;
      end_of_slave_access_q <= 1'b0;
      rxHold_q <= `ISIH_BYTE_RESET;
    end else begin
      if (compSet) begin
        transfer_complete_q <= 1'b1;
      end else if (compClr) begin
        transfer_complete_q <= 1'b0;
      end
      if (rxSet) begin
        rx_ready_q <= 1'b1;
        rxHold_q <= mRx ? mstRxByte : shift_q;
      end else if (rdRx) begin
        rx_ready_q <= 1'b0;
      end
      if (txRdySet) begin
        tx_ready_q <= 1'b1;
      end else if (wrTx) begin
        tx_ready_q <= 1'b0;
      end
      if (ackAddr) begin
        slave_read_dir_q <= shift_q[0];
      end
      if (ackAddr) begin
        slave_access_q <= 1'b1;
      end else if (svAccEnd) begin
        slave_access_q <= 1'b0;
      end
      if (ackAddr && gcHit) begin
        general_call_seen_q <= 1'b1;
      end else if (rdStatus) begin
        general_call_seen_q <= 1'b0;
      end
      if (mRx && rx_ready_q) begin
        overrun_error_q <= 1'b1;
      end else if (rdStatus) begin
        overrun_error_q <= 1'b0;
      end
      if (mNack || slvNack) begin
        nack_q <= 1'b1;
      end else if (rdStatus) begin
        nack_q <= 1'b0;
      end
      if (mArb) begin
        arbLost_q <= 1'b1;
      end else if (rdStatus) begin
        arbLost_q <= 1'b0;
      end
      if (svAccEnd && !ackAddr) begin
        end_of_slave_access_q <= 1'b1;
      end else if (rdStatus) begin
        end_of_slave_access_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // status vector, interrupt, read port
  // ----------------------------------------
  wire [11:0] flagVec = {end_of_slave_access_q, stretch_q, arbLost_q, nack_q, 1'b0, overrun_error_q, general_call_seen_q,
                         slave_access_q, slave_read_dir_q, tx_ready_q, rx_ready_q, transfer_complete_q};
  wire [31:0] statusWord = {16'h0000, `ISIH_STATUS_HIGH_ONES, flagVec};

  assign irq = |(flagVec & mask_q & `ISIH_IRQ_VALID);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        `ISIH_OFS_MODE: regRdata <= {30'h00000000, modeSlave_q, modeMaster_q};
        `ISIH_OFS_OWN_ADDR: regRdata <= {9'h000, ownAddr_q, 16'h0000};
        `ISIH_OFS_STATUS: regRdata <= statusWord;
        `ISIH_OFS_IRQ_MASK: regRdata <= {20'h00000, mask_q};
        `ISIH_OFS_RX_HOLD: regRdata <= {24'h000000, rxHold_q};
        `ISIH_OFS_TX_HOLD: regRdata <= {24'h000000, txHold_q};
        default: regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end

endmodule // isih_status_irq

// >>> verification/isih_status_irq_sva.sv
`timescale 1ns/1ps
`include "isih_defines.vh"
// ----
// port checks
// ----
module isih_status_irq_sva (
  input wire core_clk, // clock
  input wire rst_n, // reset
  input wire [31:0] regAddr, // address
  input wire [31:0] regWdata, // write data
  input wire regWr, // write strobe
  input wire regRd, // read strobe
  input wire [31:0] regRdata, // read data
  input wire mstTxTake, // byte taken
  input wire mstByteNack, // data nack
  input wire [7:0] txByte, // byte out
  input wire txPending, // holding full
  input wire masterEn, // master mode
  input wire irq // interrupt
);
  wire txWr = regWr && regAddr == `ISIH_OFS_TX_HOLD;
  wire rdAt = regRd && regAddr == `ISIH_OFS_IRQ_MASK;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rd_idle; !regRd |=> regRdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("data outside read");
  property p_wo_zero;
    regRd && (regAddr == `ISIH_OFS_IRQ_SET || regAddr == `ISIH_OFS_IRQ_CLR) |=> regRdata == 0;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("enable regs read");
  property p_rx_hi; regRd && regAddr == `ISIH_OFS_RX_HOLD |=> regRdata[31:8] == 24'h0; endproperty
  a_rx_hi: assert property (p_rx_hi) else $error("rx upper bits");
  property p_mask_fld; rdAt |=> (regRdata & ~32'h00000F77) == 0; endproperty
  a_mask_fld: assert property (p_mask_fld) else $error("mask layout");
  property p_st_hi; regRd && regAddr == `ISIH_OFS_STATUS |=> regRdata[15:12] == 4'hF; endproperty
  a_st_hi: assert property (p_st_hi) else $error("status high bits");
  property p_tx_byte; txWr ##1 !txWr |=> txByte == $past(regWdata[7:0], 2); endproperty
  a_tx_byte: assert property (p_tx_byte) else $error("tx byte");
  property p_tx_pend; masterEn && txWr && !mstTxTake |=> ##[0:1] txPending; endproperty
  a_tx_pend: assert property (p_tx_pend) else $error("tx pending");
  property p_nack_rdy; masterEn && mstByteNack && !txWr |=> ##[0:1] !txPending; endproperty
  a_nack_rdy: assert property (p_nack_rdy) else $error("nack ready");
  property p_irq_off; rdAt ##1 regRdata == 0 |-> !irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq unmasked");
endmodule // isih_status_irq_sva

bind isih_status_irq isih_status_irq_sva u_sva (.core_clk, .rst_n, .regAddr, .regWdata, .regWr,
  .regRd, .regRdata, .mstTxTake, .mstByteNack, .txByte, .txPending, .masterEn, .irq);

// >>> verification/isih_i2c_master_model.sv
`timescale 1ns/1ps
// ----
// far-side bus master
// ----
module isih_i2c_master_model (
  input wire scl, // clock level
  input wire sda, // data level
  output reg sclLow, // pull clock low
  output reg sdaLow // pull data low
);
  integer n;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // release clock, wait out a stretch
  task sclHigh;
    begin
      sclLow = 1'b0;
      n = 0;
      while (!scl && n < 40000) begin
        #1;
        n = n + 1;
      end
      #12;
    end
  endtask
  task bitOut(input val);
    begin
      sdaLow = !val;
      #12;
      sclHigh;
      #12;
      sclLow = 1'b1;
      #12;
    end
  endtask
  task bitIn(output val);
    begin
      sdaLow = 1'b0;
      #12;
      sclHigh;
      val = sda;
      #12;
      sclLow = 1'b1;
      #12;
    end
  endtask
  task frameStart;
    begin
      sdaLow = 1'b1;
      #24;
      sclLow = 1'b1;
      #12;
    end
  endtask
  task frameStop;
    begin
      sdaLow = 1'b1;
      #12;
      sclHigh;
      #12;
      sdaLow = 1'b0;
      #24;
    end
  endtask
  task byteOut(input [7:0] val, output ack);
    integer k;
    reg bt;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bitOut(val[k]);
      bitIn(bt);
      ack = !bt;
    end
  endtask
  task byteIn(input ack, output [7:0] val);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bitIn(val[k]);
      bitOut(!ack);
    end
  endtask
endmodule // isih_i2c_master_model

// >>> verification/isih_status_irq_tb.sv
`timescale 1ns/1ps
`include "isih_defines.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t: got %h want %h", $time, g, e); end end
module isih_status_irq_tb;
  localparam [31:0] AST = `ISIH_OFS_STATUS;
  localparam [31:0] AMSK = `ISIH_OFS_IRQ_MASK;
  localparam [31:0] ASET = `ISIH_OFS_IRQ_SET;
  localparam [31:0] ARX = `ISIH_OFS_RX_HOLD;
  localparam [31:0] ATX = `ISIH_OFS_TX_HOLD;
  localparam [31:0] ALL = 32'hFFFFFFFF;
  reg core_clk = 0;
  reg rst_n = 0;
  reg [31:0] regAddr = 0;
  reg [31:0] regWdata = 0;
  reg regWr = 0;
  reg regRd = 0;
  reg [5:0] mst = 0;
  reg [7:0] mstRxByte = 0;
  wire [31:0] regRdata;
  wire [7:0] txByte;
  wire sclOut, sclOe, sdaOut, sdaOe, txPending, masterEn, slaveEn, irq, mSclLow, mSdaLow;
  wire scl = !mSclLow && (!sclOe || sclOut);
  wire sda = !mSdaLow && (!sdaOe || sdaOut);
  integer n_mismatch = 0;
  integer samples_checked = 0;
  integer i;
  reg [31:0] m, s, c, v;
  reg [7:0] b;
  reg [6:0] own;
  reg a;
  always #2.5 core_clk = ~core_clk;
  isih_status_irq dut (.core_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .sclIn(scl), .sclOut, .sclOe, .sdaIn(sda), .sdaOut, .sdaOe, .mstStart(mst[0]),
    .mstTxTake(mst[1]), .mstRxValid(mst[2]), .mstRxByte, .mstByteNack(mst[3]),
    .mstArbLost(mst[4]), .mstDone(mst[5]), .txByte, .txPending, .masterEn, .slaveEn, .irq);
  isih_i2c_master_model pm (.scl, .sda, .sclLow(mSclLow), .sdaLow(mSdaLow));
  function [31:0] nextMask(input [31:0] old, input [31:0] en, input [31:0] dis);
    nextMask = (old | en) & ~dis & 32'h00000F77;
  endfunction
  task wr(input [31:0] ad, input [31:0] val);
    begin
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= ad;
      regWdata <= val;
      @(posedge core_clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [31:0] ad, input [31:0] msk, input [31:0] want);
    begin
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= ad;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1;
      `CHK(regRdata & msk, want)
    end
  endtask
  task pulse(input integer k);
    begin
      @(posedge core_clk);
      mst <= 6'h01 << k;
      @(posedge core_clk);
      mst <= 6'h00;
    end
  endtask
  task waitStretch;
    begin
      i = 0;
      while (!sclOe && i < 400) begin
        @(posedge core_clk);
        #1;
        i = i + 1;
      end
    end
  endtask
  task summarize;
    begin
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    #300000;
    n_mismatch = n_mismatch + 1;
    $display("ERROR %0t: watchdog", $time);
    summarize;
  end
  initial begin
    s = $urandom(23526);
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(AMSK, ALL, 32'h0);
    rd(AST, ALL, 32'h0000F009);
    rd(ASET, ALL, 32'h0);
    rd(32'hFFF8403C, ALL, 32'h0);
    $display("reset test done");
    m = 32'h0;
    for (i = 0; i < 22; i = i + 1) begin
      s = (i == 20) ? ALL : $urandom;
      c = (i == 21) ? ALL : (i == 20) ? 32'h0 : $urandom;
      wr(ASET, s);
      wr(`ISIH_OFS_IRQ_CLR, c);
      m = nextMask(m, s, c);
      rd(AMSK, ALL, m);
    end
    $display("mask test done");
    wr(`ISIH_OFS_MODE, 32'h3);
    #1;
    `CHK({masterEn, slaveEn}, 2'b10)
    wr(ASET, 32'h100);
    pulse(0);
    pulse(3);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(irq, 1'b1)
    rd(AST, 32'h305, 32'h105);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(irq, 1'b0)
    rd(AST, 32'h100, 32'h0);
    pulse(0);
    pulse(4);
    rd(AST, 32'h301, 32'h201);
    rd(AST, 32'h200, 32'h0);
    pulse(0);
    rd(AST, 32'h1, 32'h0);
    pulse(5);
    rd(AST, 32'h1, 32'h1);
    for (i = 0; i < 4; i = i + 1) begin
      b = $urandom;
      v = $urandom;
      mstRxByte <= b;
      pulse(2);
      rd(ARX, ALL, {24'h0, b});
      wr(ATX, v);
      @(posedge core_clk);
      #1;
      `CHK(txByte, v[7:0])
      rd(ATX, 32'hFF, {24'h0, v[7:0]});
      pulse(1);
    end
    pulse(2);
    pulse(2);
    rd(AST, 32'h42, 32'h42);
    rd(AST, 32'h40, 32'h0);
    rd(ARX, ALL, {24'h0, b});
    $display("master test done");
    wr(`ISIH_OFS_MODE, 32'h0);
    own = $urandom_range(127, 1);
    wr(`ISIH_OFS_OWN_ADDR, {9'h0, own, 16'h0});
    wr(`ISIH_OFS_MODE, 32'h2);
    #1;
    `CHK({masterEn, slaveEn}, 2'b01)
    b = $urandom;
    pm.frameStart;
    pm.byteOut({own, 1'b0}, a);
    `CHK(a, 1'b1)
    rd(AST, 32'h18, 32'h10);
    pm.byteOut(b, a);
    `CHK(a, 1'b1)
    fork
      pm.frameStop;
      begin
        waitStretch;
        rd(AST, 32'h41A, 32'h412);
        rd(ARX, ALL, {24'h0, b});
      end
    join
    repeat (4) @(posedge core_clk);
    rd(AST, 32'hC11, 32'h801);
    rd(AST, 32'h800, 32'h0);
    $display("slave write test done");
    pm.frameStart;
    pm.byteOut({own, 1'b1}, a);
    `CHK(a, 1'b1)
    v = $urandom;
    fork
      pm.byteIn(1'b0, b);
      begin
        waitStretch;
        rd(AST, 32'h41C, 32'h41C);
        wr(ATX, v);
      end
    join
    `CHK(b, v[7:0])
    rd(AST, 32'h104, 32'h104);
    pm.bitIn(a); // slave leaves data line released after nack
    `CHK(a, 1'b1)
    pm.frameStop;
    $display("slave read test done");
    repeat (4) @(posedge core_clk);
    pm.frameStart;
    pm.byteOut(8'h00, a);
    `CHK(a, 1'b1)
    rd(AST, 32'h30, 32'h30);
    rd(AST, 32'h20, 32'h0);
    pm.frameStop;
    $display("general call test done");
    summarize;
  end
endmodule // isih_status_irq_tb
